// ---- logic/elapsed_time_capture_counter.sv ----
// elapsed time counter with five-byte capture register and re-arm on read
// Functional notes
// - capture on pin edge or chip-select fall
// - pin polarity invert picks the active edge
// - accepted event latches count into 40-bit capture
// - capture shown as one 40-bit output of five bytes
// - reading least significant byte re-arms capture
// - counter clock is osc3 /8 or osc2 /20
// - source select 0 picks osc3, 1 osc2
// - trigger select 1 pin, 0 chip select
// - counts and captures only while enabled
// - armed chip-select fall latches the count
// - msb read blocks chip-select captures until lsb
// - capture and re-arm within one multibyte read
// - counts up, wraps from maximum to zero
// - disabled counter held at zero
// - function 0x27 pin locks after capture until lsb
`timescale 1ns/100ps
`default_nettype none
module elapsed_time_capture_counter
  import elapsed_counter_pkg::*;
(
  // clock and reset
  input  wire logic                                     I_CLK,
  input  wire logic                                     I_SYS_RST,
  // oscillator cycle pulses, one per oscillator period seen at I_CLK
  input  wire logic                                     I_OSC3_TICK,
  input  wire logic                                     I_OSC2_TICK,
  // configuration
  input  wire logic                                     I_COUNTER_CLOCK_SOURCE_SELECT,
  input  wire logic                                     I_COUNTER_RUN_ENABLE,
  input  wire logic                                     I_CAPTURE_TRIGGER_SELECT,
  input  wire logic [elapsed_counter_pkg::PIN_N-1:0]    I_PIN_POLARITY_INVERT,
  input  wire logic [elapsed_counter_pkg::PIN_N*elapsed_counter_pkg::FUNC_W-1:0] I_PIN_FUNCTION_SELECT,
  // trigger sources
  input  wire logic [elapsed_counter_pkg::PIN_N-1:0]    I_PIN_LEVEL,
  input  wire logic                                     I_SERIAL_CHIP_SELECT_N,
  // serial engine read reports, one-cycle pulses
  input  wire logic                                     I_READ_MSB_STROBE,
  input  wire logic                                     I_READ_LSB_STROBE,
  // results
  output logic [elapsed_counter_pkg::COUNT_W-1:0]       O_ELAPSED_COUNTER,
  output logic [elapsed_counter_pkg::BYTE_N*elapsed_counter_pkg::BYTE_W-1:0] O_CAPTURED_COUNT,
  output logic                                          O_CAPTURE_ARMED
);
  import elapsed_counter_pkg::*;

  // ==========================================================
  // trigger synchronisers
  logic [PIN_N-1:0] pin_s1_r, pin_s2_r, pin_s3_r;
  logic [PIN_N-1:0] pin_s1_nxt, pin_s2_nxt, pin_s3_nxt;
  logic [PIN_N-1:0] pin_edge;
  logic             cs_s1_r, cs_s2_r, cs_s3_r;
  logic             cs_fall;
  logic             pin_fire;

  // first stage feeds only the second; edges look at stages two and three
  always_comb begin
    pin_s1_nxt = I_PIN_LEVEL;
    pin_s2_nxt = pin_s1_r;
    pin_s3_nxt = pin_s2_r;
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      cs_s1_r  <= 1'h1;
      cs_s2_r  <= 1'h1;
      cs_s3_r  <= 1'h1;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
      pin_s3_r <= pin_s3_nxt;
      cs_s1_r  <= I_SERIAL_CHIP_SELECT_N;
      cs_s2_r  <= cs_s1_r;
      cs_s3_r  <= cs_s2_r;
    end
  end

  // per pin: polarity picks the edge, only trigger-function pins count
  generate
    for (genvar p = 0; p < PIN_N; p++) begin : g_pin
      assign pin_edge[p] = (I_PIN_FUNCTION_SELECT[p*FUNC_W +: FUNC_W] == FUNC_CAP_TRIG)
                         & (pin_s2_r[p] ^ I_PIN_POLARITY_INVERT[p])
                         & ~(pin_s3_r[p] ^ I_PIN_POLARITY_INVERT[p]);
    end
  endgenerate

  assign pin_fire = |pin_edge;
  assign cs_fall  = cs_s3_r & ~cs_s2_r;

  // ==========================================================
  // prescaler and free-running counter
  logic [PRE_W-1:0]   pre_r, pre_nxt;
  logic [COUNT_W-1:0] count_r, count_nxt;
  logic               osc_tick;
  logic [PRE_W-1:0]   div_last;
  logic               count_step;

  assign osc_tick   = (I_COUNTER_CLOCK_SOURCE_SELECT == SRC_OSC3) ? I_OSC3_TICK : I_OSC2_TICK;
  assign div_last   = (I_COUNTER_CLOCK_SOURCE_SELECT == SRC_OSC3) ? (DIV_OSC3 - 5'h01)
                                                                  : (DIV_OSC2 - 5'h01);
  // prescaler runs past a smaller ratio after a source switch; >= recovers at once
  assign count_step = osc_tick && (pre_r >= div_last);

  always_comb begin
    pre_nxt   = pre_r;
    count_nxt = count_r;
    if (!I_COUNTER_RUN_ENABLE) begin
      pre_nxt   = PRE_RST;
      count_nxt = COUNT_RST;
    end else if (osc_tick) begin
      if (count_step) begin
        pre_nxt   = PRE_RST;
        count_nxt = count_r + 40'h00_0000_0001;
      end else begin
        pre_nxt = pre_r + 5'h01;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pre_r   <= PRE_RST;
      count_r <= COUNT_RST;
    end else begin
      pre_r   <= pre_nxt;
      count_r <= count_nxt;
    end
  end

  // ==========================================================
  // capture register and arm state
  arm_state_t         arm_r, arm_nxt;
  logic [COUNT_W-1:0] cap_r, cap_nxt;
  logic               take_pin, take_cs, take;

  // a locked capture ignores every trigger until the low byte is read
  assign take_pin = I_COUNTER_RUN_ENABLE && (I_CAPTURE_TRIGGER_SELECT == TRIG_PIN)
                    && pin_fire && (arm_r == ST_ARMED);
  assign take_cs  = I_COUNTER_RUN_ENABLE && (I_CAPTURE_TRIGGER_SELECT != TRIG_PIN)
                    && cs_fall && (arm_r == ST_ARMED);
  assign take     = take_pin || take_cs;

  always_comb begin
    cap_nxt = cap_r;
    arm_nxt = arm_r;
    if (take) begin
      cap_nxt = count_r;
    end
    case (arm_r)
      ST_ARMED: begin
        // pin capture locks itself; chip-select mode locks once msb read
        if (take_pin) begin
          arm_nxt = ST_LOCKED;
        end else if ((I_CAPTURE_TRIGGER_SELECT != TRIG_PIN) && I_READ_MSB_STROBE) begin
          arm_nxt = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        // the same path lets one multibyte read capture, lock and re-arm
        if (I_READ_LSB_STROBE) begin
          arm_nxt = ST_ARMED;
        end
      end
      default: arm_nxt = ST_ARMED;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      arm_r <= ST_ARMED;
      cap_r <= COUNT_RST;
    end else begin
      arm_r <= arm_nxt;
      cap_r <= cap_nxt;
    end
  end

  // outputs come straight from flops
  assign O_ELAPSED_COUNTER = count_r;
  assign O_CAPTURED_COUNT  = cap_r;
  // bit 0 of the one-hot arm code is the armed flop itself, no decode after it
  assign O_CAPTURE_ARMED   = arm_r[0];

  // ==========================================================
  // checks
  held_zero_a : assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !I_COUNTER_RUN_ENABLE |=> (count_r == COUNT_RST) && (pre_r == PRE_RST))
    else $error("counter not held at zero while disabled");
  count_step_a : assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_COUNTER_RUN_ENABLE && count_step |=> count_r == $past(count_r) + 40'h00_0000_0001)
    else $error("counter did not advance on prescaler wrap");
  count_hold_a : assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_COUNTER_RUN_ENABLE && !count_step |=> $stable(count_r))
    else $error("counter moved without prescaler wrap");
  capture_take_a : assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    take |=> cap_r == $past(count_r))
    else $error("capture did not take the counter value");
  capture_hold_a : assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !O_CAPTURE_ARMED |=> $stable(cap_r))
    else $error("capture changed while locked");
  pin_lock_a : assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    take_pin |=> !O_CAPTURE_ARMED [*1] ##0 (cap_r == $past(count_r)))
    else $error("pin capture did not lock");
  lsb_rearm_a : assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !O_CAPTURE_ARMED && I_READ_LSB_STROBE |=> O_CAPTURE_ARMED)
    else $error("low byte read did not re-arm");
  cs_capture_a : assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    cs_s3_r && !cs_s2_r && O_CAPTURE_ARMED && I_COUNTER_RUN_ENABLE
    && !I_CAPTURE_TRIGGER_SELECT |=> cap_r == $past(count_r))
    else $error("armed chip-select fall did not capture");
  no_run_cap_a : assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !I_COUNTER_RUN_ENABLE |=> $stable(cap_r))
    else $error("capture while counter disabled");

endmodule : elapsed_time_capture_counter
`default_nettype wire

// ---- logic/elapsed_counter_pkg.sv ----
// constants shared by the elapsed time capture counter
package elapsed_counter_pkg;
  // ==========================================================
  // widths
  localparam int COUNT_W = 40;            // free-running count width
  localparam int BYTE_W  = 8;             // one captured byte
  localparam int BYTE_N  = 5;             // captured value spans five bytes
  localparam int PIN_N   = 3;             // general-purpose pins watched
  localparam int FUNC_W  = 8;             // pin function field width
  localparam int PRE_W   = 5;             // prescaler width (holds 0..19)
  // ==========================================================
  // divider ratios of the counter clock
  localparam logic [PRE_W-1:0] DIV_OSC3 = 5'h08;   // third loop oscillator / 8
  localparam logic [PRE_W-1:0] DIV_OSC2 = 5'h14;   // second loop oscillator / 20
  // ==========================================================
  // field encodings and reset values
  localparam logic              SRC_OSC3      = 1'h0;   // source select value for loop three
  localparam logic              TRIG_PIN      = 1'h1;   // trigger select value for pin trigger
  localparam logic [FUNC_W-1:0] FUNC_CAP_TRIG = 8'h27;  // pin function: capture trigger
  localparam logic [COUNT_W-1:0] COUNT_RST    = 40'h00_0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX    = 40'hFF_FFFF_FFFF;
  localparam logic [PRE_W-1:0]   PRE_RST      = 5'h00;
  // ==========================================================
  // capture arm state, one-hot
  typedef enum logic [1:0] {
    ST_ARMED  = 2'h1,
    ST_LOCKED = 2'h2
  } arm_state_t;
endpackage : elapsed_counter_pkg

// ---- testbench/host_trigger_model.sv ----
// host and trigger source model: chip select frames, byte read reports, pin edges
`timescale 1ns/100ps
`default_nettype none
module host_trigger_model (
  // clock
  input  wire logic       i_clk,
  // toward the counter
  output var logic        o_cs_n,
  output var logic        o_rd_msb,
  output var logic        o_rd_lsb,
  output var logic [2:0]  o_pin
);
  // ==========================================================
  // idle levels: select released high, pins low
  initial begin
    o_cs_n   = 1'b1;
    o_rd_msb = 1'b0;
    o_rd_lsb = 1'b0;
    o_pin    = 3'h0;
  end

  // one frame: select falls, optional msb then lsb read reports, then released
  // reads wait four edges so the fall has cleared the synchroniser first
  task automatic frame(input logic msb, input logic lsb);
    @(posedge i_clk) o_cs_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_rd_msb <= msb;
    @(posedge i_clk) o_rd_msb <= 1'b0;
    o_rd_lsb <= lsb;
    @(posedge i_clk) o_rd_lsb <= 1'b0;
    o_cs_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    // hand back on a falling edge so callers read settled outputs
    @(negedge i_clk);
  endtask : frame

  // pin level change, held long enough for the synchroniser
  task automatic pin(input int idx, input logic lvl);
    @(posedge i_clk) o_pin[idx] <= lvl;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
  endtask : pin
endmodule : host_trigger_model
`default_nettype wire

// ---- testbench/test_elapsed_time_capture_counter.sv ----
// self-checking bench for the elapsed time capture counter
`timescale 1ns/100ps
`default_nettype none
module test_elapsed_time_capture_counter;
  import elapsed_counter_pkg::*;
  logic clk = 1'b0;
  logic rst, tick3, tick2, src, en, trig, cs_n, rd_msb, rd_lsb, armed;
  logic [2:0]  pol, pin;
  logic [23:0] func;
  logic [39:0] cnt, cap, base;
  int fail_count, compares;

  elapsed_time_capture_counter dut (.I_CLK(clk), .I_SYS_RST(rst), .I_OSC3_TICK(tick3),
    .I_OSC2_TICK(tick2), .I_COUNTER_CLOCK_SOURCE_SELECT(src), .I_COUNTER_RUN_ENABLE(en),
    .I_CAPTURE_TRIGGER_SELECT(trig), .I_PIN_POLARITY_INVERT(pol), .I_PIN_FUNCTION_SELECT(func),
    .I_PIN_LEVEL(pin), .I_SERIAL_CHIP_SELECT_N(cs_n), .I_READ_MSB_STROBE(rd_msb),
    .I_READ_LSB_STROBE(rd_lsb), .O_ELAPSED_COUNTER(cnt), .O_CAPTURED_COUNT(cap),
    .O_CAPTURE_ARMED(armed));
  host_trigger_model host (.i_clk(clk), .o_cs_n(cs_n), .o_rd_msb(rd_msb), .o_rd_lsb(rd_lsb),
    .o_pin(pin));

  // ==========================================================
  // clock and checking helpers
  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // bounded wait for the arm flag; running out counts as a mismatch
  task automatic wait_armed(input logic lvl);
    int n;
    for (n = 0; n < 20 && armed !== lvl; n++) @(negedge clk);
    if (armed !== lvl) begin
      chk("armed wait", {39'h0, lvl}, {39'h0, armed});
      tally_and_finish();
    end
  endtask : wait_armed

  // second-loop ticks for n cycles, then the count stands still
  task automatic burst(input int n);
    @(posedge clk) tick2 <= 1'b1;
    repeat (n) @(posedge clk);
    tick2 <= 1'b0;
    @(negedge clk) base = cnt;
  endtask : burst

  // ==========================================================
  // main sequence
  initial begin
    {tick3, tick2, src, en, trig, pol, func} = '0;
    fail_count = 0;
    compares = 0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("count", 40'h0, cnt);
    chk("capture", 40'h0, cap);
    chk("armed", 40'h1, {39'h0, armed});
    // loop three divided by eight: 80 ticks give 10 steps
    @(posedge clk) en <= 1'b1;
    tick3 <= 1'b1;
    repeat (20) @(negedge clk);
    base = cnt;
    repeat (80) @(negedge clk);
    chk("osc3 steps", base + 40'hA, cnt);
    // loop two selected: loop three ticks refused, then 80 ticks give 4 steps
    @(posedge clk) src <= 1'b1;
    @(negedge clk) base = cnt;
    repeat (40) @(negedge clk);
    chk("osc3 ignored", base, cnt);
    @(posedge clk) tick2 <= 1'b1;
    repeat (40) @(negedge clk);
    base = cnt;
    repeat (80) @(negedge clk);
    chk("osc2 steps", base + 40'h4, cnt);
    // disable holds at zero
    @(posedge clk) en <= 1'b0;
    tick2 <= 1'b0;
    repeat (2) @(negedge clk);
    chk("count off", 40'h0, cnt);
    // restart from zero before measuring, so no rollover between captures
    @(posedge clk) en <= 1'b1;
    // pin trigger, rising edge on pin 0; pin 1 not configured
    @(posedge clk) trig <= 1'b1;
    func <= {16'h0, FUNC_CAP_TRIG};
    burst(60);
    host.pin(1, 1'b1);
    chk("armed pin1", 40'h1, {39'h0, armed});
    host.pin(0, 1'b1);
    wait_armed(1'b0);
    chk("pin capture", base, cap);
    burst(40);
    host.pin(0, 1'b0);
    host.pin(0, 1'b1);
    chk("locked pin", base - 40'h2, cap);
    host.frame(1'b0, 1'b1);
    wait_armed(1'b1);
    // chip-select falls are refused while the pin trigger is chosen
    host.frame(1'b0, 1'b0);
    chk("cs ignored", base - 40'h2, cap);
    // inverted polarity: the falling edge captures
    @(posedge clk) pol <= 3'h1;
    burst(40);
    host.pin(0, 1'b0);
    chk("falling capture", base, cap);
    host.frame(1'b0, 1'b1);
    // chip-select trigger: every armed fall captures
    @(posedge clk) trig <= 1'b0;
    burst(40);
    host.frame(1'b0, 1'b0);
    chk("cs capture", base, cap);
    burst(40);
    host.frame(1'b1, 1'b0);
    chk("cs again", base, cap);
    chk("msb locks", 40'h0, {39'h0, armed});
    burst(40);
    host.frame(1'b0, 1'b0);
    chk("locked cs", base - 40'h2, cap);
    host.frame(1'b0, 1'b1);
    chk("lsb rearms", 40'h1, {39'h0, armed});
    chk("no capture", base - 40'h2, cap);
    // inverted pin falling edge would fire, but chip select is chosen
    host.pin(0, 1'b1);
    host.pin(0, 1'b0);
    chk("pin ignored", base - 40'h2, cap);
    // multibyte read: capture, lock and re-arm in one frame
    burst(40);
    host.frame(1'b1, 1'b1);
    chk("multibyte cap", base, cap);
    chk("multibyte arm", 40'h1, {39'h0, armed});
    // disabled counter refuses captures
    @(posedge clk) en <= 1'b0;
    host.frame(1'b0, 1'b0);
    chk("off refused", base, cap);
    tally_and_finish();
  end
endmodule : test_elapsed_time_capture_counter
`default_nettype wire
